/* File: core/xbs_pipe.sv */
// Issue control with crossbar stage, scoreboard bypass and pointer checking.
`timescale 1ns/1ns
`default_nettype none
module xbs_pipe
  import xbs_pkg::*;
#(
  parameter int NUM_CHAN_P = NUM_CHAN,
  parameter logic [DATA_W-1:0] HANDLER_ADDR = 64'h0000_0000_0000_1000,
  localparam int CH_W = $clog2(NUM_CHAN_P + 1)
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                iss_valid,
  input  wire xbs_op_type          iss_op,
  input  wire logic [REG_W-1:0]    iss_src_a,
  input  wire logic [REG_W-1:0]    iss_src_b,
  input  wire logic [REG_W-1:0]    iss_dst,
  input  wire logic [REG_W-1:0]    iss_ptr,
  input  wire logic [LAT_W-1:0]    iss_lat,
  input  wire logic [DATA_W-1:0]   iss_ptr_val,
  input  wire logic [IMM_W-1:0]    iss_imm,
  input  wire logic [STREAM_W-1:0] iss_stream,
  input  wire xbs_cache_type       iss_cache,
  output logic                     iss_ready,
  output logic                     iss_fault,
  output logic                     xb_valid,
  output xbs_op_type               xb_op,
  output logic [CH_W-1:0]          xb_sel_a,
  output logic [CH_W-1:0]          xb_sel_b,
  output logic [REG_W-1:0]         xb_dst,
  output logic [CH_W-1:0]          xb_wb_chan,
  output logic                     ls_valid,
  output logic                     ls_store,
  output logic [REG_W-1:0]         ls_dst,
  output logic [DATA_W-1:0]        ls_addr,
  output logic [DATA_W-1:0]        ls_ptr_next,
  output logic                     ls_unit,
  output logic                     ls_bank,
  output xbs_cache_type            ls_cache,
  output logic                     jmp_valid,
  output logic [DATA_W-1:0]        jmp_target,
  output logic                     tlb_req,
  output logic [REG_W-1:0]         tlb_reg,
  output logic [DATA_W-1:0]        tlb_addr,
  input  wire logic                tlb_ack,
  input  wire logic [REG_W-1:0]    tlb_ack_reg,
  input  wire logic                tlb_hit,
  output logic                     pf_valid,
  output logic [DATA_W-1:0]        pf_addr,
  output logic                     pf_handler
);
  localparam int MAX_SLOT = (1 << LAT_W) + 1;

  if (NUM_CHAN_P < 2 || NUM_CHAN_P > 7 || STREAM_W != 2) begin : g_bad_cfg
    $error("Unsupported channel count or stream hint width.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decoding shared by issue logic and checks.
  function automatic logic is_ls(input xbs_op_type op);
    return op inside {XBS_OP_LOAD, XBS_OP_STORE};
  endfunction
  function automatic logic uses_ptr(input xbs_op_type op);
    return is_ls(op) || op == XBS_OP_JUMP;
  endfunction
  function automatic logic writes_dst(input xbs_op_type op);
    return op inside {XBS_OP_CALC, XBS_OP_MOVE, XBS_OP_LOAD};
  endfunction
  function automatic logic uses_a(input xbs_op_type op);
    return op inside {XBS_OP_CALC, XBS_OP_MOVE};
  endfunction
  function automatic logic uses_b(input xbs_op_type op);
    return op inside {XBS_OP_CALC, XBS_OP_STORE};
  endfunction
  // Operand source: zero is the register set, otherwise bypass channel plus one.
  function automatic logic [CH_W-1:0] sel_of(input logic [SB_W-1:0] c,
                                             input logic [CH_W-1:0] ch);
    return (c == SB_BYPASS) ? ch + CH_W'(1) : '0;
  endfunction

  logic [SB_W-1:0] sb_cnt [NREG];
  logic [SB_W-1:0] next_cnt [NREG];
  logic [CH_W-1:0] chan_of [NREG];
  logic [CH_W-1:0] next_chan [NREG];
  logic [CH_W-1:0] slot_use [MAX_SLOT+1];
  logic [CH_W-1:0] next_slot [MAX_SLOT+1];

  xbs_ptr_if pif ();

  ////////////////////////////////////////////////////////////////////////////
  // Issue decode and write-back slot choice.
  wire logic              u_ls     = is_ls(iss_op);
  wire logic              u_ptr    = uses_ptr(iss_op);
  wire logic              u_wr     = writes_dst(iss_op);
  wire logic              op_assoc = iss_op == XBS_OP_ASSOC;
  wire logic [SB_W-1:0]   lat_ext  = {1'b0, iss_lat};
  wire logic [SB_W-1:0]   wb_slot  =
    (iss_op == XBS_OP_MOVE) ? SB_MOVE :
    (iss_op == XBS_OP_LOAD) ? ((lat_ext == '0) ? SB_ONE : lat_ext) :
    lat_ext + SB_XBAR;
  wire logic [CH_W-1:0]   wb_chan  = slot_use[wb_slot];
  wire logic              wb_full  = u_wr && wb_chan >= CH_W'(NUM_CHAN_P);

  // Dependency stalls against the scoreboard countdowns.
  wire logic a_wait   = uses_a(iss_op) && sb_cnt[iss_src_a] > SB_BYPASS;
  wire logic b_wait   = uses_b(iss_op) && sb_cnt[iss_src_b] > SB_BYPASS;
  wire logic ptr_busy = sb_cnt[iss_ptr] != '0;
  wire logic [CH_W-1:0] sel_a = uses_a(iss_op) ?
    sel_of(sb_cnt[iss_src_a], chan_of[iss_src_a]) : '0;
  wire logic [CH_W-1:0] sel_b = uses_b(iss_op) ?
    sel_of(sb_cnt[iss_src_b], chan_of[iss_src_b]) : '0;

  // Pointer arithmetic: the access uses the pointer itself, then adds the offset.
  wire logic [DATA_W-1:0] imm_ext  = {{(DATA_W-IMM_W){iss_imm[IMM_W-1]}}, iss_imm};
  wire logic [DATA_W-1:0] ptr_next = iss_ptr_val + imm_ext;
  wire logic same_page = ptr_next[DATA_W-1:PAGE_LSB] == iss_ptr_val[DATA_W-1:PAGE_LSB];
  wire xbs_ptr_type q_state = pif.q_state;

  // Decode-time faults and pointer readiness.
  wire logic bad_hint   = u_ls && iss_cache == XBS_CH_RSVD;
  wire logic ptr_bad    = u_ptr && q_state == XBS_PT_BAD;
  wire logic line_fault = (op_assoc || (u_ptr && q_state == XBS_PT_NONE)) &&
                          pif.conflict && !ptr_busy;
  wire logic ptr_wait   = (u_ptr || op_assoc) &&
                          (ptr_busy || (u_ptr && q_state != XBS_PT_VALID));
  wire logic stall      = a_wait || b_wait || wb_full || ptr_wait;

  // A faulting instruction is consumed so that the trap path can take over.
  assign iss_fault = iss_valid && (bad_hint || ptr_bad || line_fault);
  assign iss_ready = iss_fault || !stall;
  wire logic take_ok  = iss_valid && iss_ready && !iss_fault;
  wire logic post_inc = take_ok && u_ls;
  wire logic auto_chk = iss_valid && u_ptr && q_state == XBS_PT_NONE &&
                        !ptr_busy && !iss_fault;

  // Requests to the pointer checker.
  assign pif.preg    = iss_ptr;
  assign pif.addr    = (u_ls && q_state == XBS_PT_VALID) ? ptr_next : iss_ptr_val;
  assign pif.req     = (take_ok && op_assoc) || auto_chk || (post_inc && !same_page);
  assign pif.upd     = post_inc && same_page;
  assign pif.inv     = take_ok && u_wr;
  assign pif.inv_reg = iss_dst;

  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard countdown and write-back channel of each register.
  for (genvar r = 0; r < NREG; r++) begin : g_sb
    wire logic hit = take_ok && u_wr && iss_dst == REG_W'(r);
    assign next_cnt[r]  = hit ? wb_slot :
                          (sb_cnt[r] != '0) ? sb_cnt[r] - SB_ONE : '0;
    assign next_chan[r] = hit ? wb_chan : chan_of[r];
  end

  // Crossbar write-back channel use per future cycle, shifting toward now.
  for (genvar i = 0; i <= MAX_SLOT; i++) begin : g_slot
    wire logic [CH_W-1:0] above;
    if (i == MAX_SLOT) begin : g_top
      assign above = '0;
    end else begin : g_mid
      assign above = slot_use[i+1];
    end
    assign next_slot[i] = above +
      CH_W'(take_ok && u_wr && wb_slot == SB_W'(i + 1));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sb_cnt   <= '{default: '0};
      chan_of  <= '{default: '0};
      slot_use <= '{default: '0};
    end else begin
      sb_cnt   <= next_cnt;
      chan_of  <= next_chan;
      slot_use <= next_slot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossbar stage register carrying operand routing and result channel.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xb_valid   <= 1'b0;
      xb_op      <= XBS_OP_NONE;
      xb_sel_a   <= '0;
      xb_sel_b   <= '0;
      xb_dst     <= '0;
      xb_wb_chan <= '0;
    end else begin
      xb_valid   <= take_ok && !op_assoc;
      xb_op      <= iss_op;
      xb_sel_a   <= sel_a;
      xb_sel_b   <= sel_b;
      xb_dst     <= iss_dst;
      xb_wb_chan <= wb_chan;
    end
  end

  // Load/store request with its stream and cache hints.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ls_valid    <= 1'b0;
      ls_store    <= 1'b0;
      ls_dst      <= '0;
      ls_addr     <= '0;
      ls_ptr_next <= '0;
      ls_unit     <= 1'b0;
      ls_bank     <= 1'b0;
      ls_cache    <= XBS_CH_KEEP;
    end else begin
      ls_valid    <= post_inc;
      ls_store    <= iss_op == XBS_OP_STORE;
      ls_dst      <= iss_dst;
      ls_addr     <= iss_ptr_val;
      ls_ptr_next <= ptr_next;
      ls_unit     <= iss_stream[STREAM_UNIT_BIT];
      ls_bank     <= iss_stream[STREAM_BANK_BIT];
      ls_cache    <= iss_cache;
    end
  end

  // Register-direct jump.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      jmp_valid  <= 1'b0;
      jmp_target <= '0;
    end else begin
      jmp_valid  <= take_ok && iss_op == XBS_OP_JUMP;
      jmp_target <= iss_ptr_val;
    end
  end

  xbs_ptr_check #(.HANDLER_ADDR (HANDLER_ADDR)) u_chk (
    .clk         (clk),
    .rst_b       (rst_b),
    .pif         (pif),
    .tlb_req     (tlb_req),
    .tlb_reg     (tlb_reg),
    .tlb_addr    (tlb_addr),
    .tlb_ack     (tlb_ack),
    .tlb_ack_reg (tlb_ack_reg),
    .tlb_hit     (tlb_hit),
    .pf_valid    (pf_valid),
    .pf_addr     (pf_addr),
    .pf_handler  (pf_handler)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [REG_W-1:0]  dst_q;
  logic [SB_W-1:0]   slot_q;
  logic [STREAM_W-1:0] stream_q;
  always_ff @(posedge clk) begin
    dst_q    <= iss_dst;
    slot_q   <= lat_ext + SB_XBAR;
    stream_q <= iss_stream;
  end

  sequence s_calc_issue;
    take_ok && iss_op == XBS_OP_CALC;
  endsequence
  sequence s_move_issue;
    take_ok && iss_op == XBS_OP_MOVE;
  endsequence

  AST_XBAR_STAGE: assert property (take_ok && !op_assoc |=> xb_valid)
    else $error("Issued instruction skipped the crossbar stage.");
  AST_CALC_GAP: assert property (s_calc_issue |=> sb_cnt[dst_q] == slot_q)
    else $error("Computation result latency is not extended by the crossbar.");
  AST_BYPASS_SEL: assert property (
    take_ok && uses_a(iss_op) && sb_cnt[iss_src_a] == SB_BYPASS |=> xb_sel_a != '0)
    else $error("Operand one cycle away was not bypassed.");
  AST_DEP_STALL: assert property (
    take_ok && uses_a(iss_op) |-> sb_cnt[iss_src_a] <= SB_BYPASS)
    else $error("Consumer issued before its producer finished.");
  AST_MOVE_B2B: assert property (s_move_issue |=> sb_cnt[dst_q] == SB_MOVE)
    else $error("Move result is not available back to back.");
  AST_POST_INC: assert property (post_inc |=> ls_valid && ls_addr == $past(iss_ptr_val))
    else $error("Access did not use the unmodified pointer.");
  AST_BAD_PTR: assert property (iss_valid && ptr_bad |-> iss_fault ##1 !ls_valid)
    else $error("Invalid pointer not trapped at decode.");
  AST_PTR_VALID: assert property (take_ok && u_ptr |-> q_state == XBS_PT_VALID)
    else $error("Unvalidated pointer entered execution.");
  AST_STREAM: assert property (post_inc |=> ls_unit == stream_q[STREAM_UNIT_BIT] &&
                                           ls_bank == stream_q[STREAM_BANK_BIT])
    else $error("Stream hint did not select unit and bank.");
  AST_HINT_RSVD: assert property (iss_valid && u_ls && iss_cache == XBS_CH_RSVD
                                  |-> iss_fault && !take_ok)
    else $error("Reserved cache hint was accepted.");
  AST_SRC_STALL: assert property (iss_valid && b_wait && !iss_fault |-> !iss_ready)
    else $error("Pending source was not stalled.");
endmodule // xbs_pipe
`default_nettype wire

/* File: core/xbs_pkg.sv */
// Shared constants and types of the crossbar scoreboard pipeline control.
package xbs_pkg;
  localparam int REG_W    = 6;
  localparam int NREG     = 64;
  localparam int DATA_W   = 64;
  localparam int IMM_W    = 16;
  localparam int LAT_W    = 4;
  localparam int STREAM_W = 2;
  localparam int SB_W     = LAT_W + 1;
  localparam int NUM_CHAN = 2;
  localparam int LINE_LSB = 6;
  localparam int PAGE_LSB = 12;
  localparam int MAX_LINE_SHARE = 2;
  // Countdown values and offsets loaded into, or compared against, the scoreboard.
  localparam logic [SB_W-1:0] SB_ONE    = 5'h01;
  localparam logic [SB_W-1:0] SB_XBAR   = 5'h01; // Extra crossbar cycle of a computation.
  localparam logic [SB_W-1:0] SB_MOVE   = 5'h01; // A move crosses the crossbar once.
  localparam logic [SB_W-1:0] SB_BYPASS = 5'h01; // Result one cycle away is bypassed.
  localparam int STREAM_UNIT_BIT = 0;
  localparam int STREAM_BANK_BIT = 1;
  typedef enum logic [2:0] {
    XBS_OP_NONE  = 3'h0,
    XBS_OP_CALC  = 3'h1,
    XBS_OP_MOVE  = 3'h2,
    XBS_OP_LOAD  = 3'h3,
    XBS_OP_STORE = 3'h4,
    XBS_OP_JUMP  = 3'h5,
    XBS_OP_ASSOC = 3'h6
  } xbs_op_type;
  typedef enum logic [1:0] {
    XBS_CH_KEEP   = 2'h0,
    XBS_CH_FLUSH  = 2'h1,
    XBS_CH_BYPASS = 2'h2,
    XBS_CH_RSVD   = 2'h3
  } xbs_cache_type;
  typedef enum logic [1:0] {
    XBS_PT_NONE  = 2'h0,
    XBS_PT_CHECK = 2'h1,
    XBS_PT_VALID = 2'h3,
    XBS_PT_BAD   = 2'h2
  } xbs_ptr_type;
endpackage

/* File: core/xbs_ptr_if.sv */
// Carrier between the issue logic and the pointer checker.
`timescale 1ns/1ns
`default_nettype none
interface xbs_ptr_if;
  import xbs_pkg::*;
  logic              req;
  logic              upd;
  logic              inv;
  logic [REG_W-1:0]  preg;
  logic [REG_W-1:0]  inv_reg;
  logic [DATA_W-1:0] addr;
  logic              conflict;
  xbs_ptr_type       q_state;
  modport pipe (output req, upd, inv, preg, inv_reg, addr, input conflict, q_state);
  modport chk  (input req, upd, inv, preg, inv_reg, addr, output conflict, q_state);
endinterface
`default_nettype wire

/* File: core/xbs_ptr_check.sv */
// Background pointer checker with TLB lookup, prefetch and cache line sharing limit.
`timescale 1ns/1ns
`default_nettype none
module xbs_ptr_check
  import xbs_pkg::*;
#(
  parameter logic [DATA_W-1:0] HANDLER_ADDR = 64'h0000_0000_0000_1000
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  xbs_ptr_if.chk                 pif,
  output logic                   tlb_req,
  output logic [REG_W-1:0]       tlb_reg,
  output logic [DATA_W-1:0]      tlb_addr,
  input  wire logic              tlb_ack,
  input  wire logic [REG_W-1:0]  tlb_ack_reg,
  input  wire logic              tlb_hit,
  output logic                   pf_valid,
  output logic [DATA_W-1:0]      pf_addr,
  output logic                   pf_handler
);
  localparam int CNT_W = $clog2(NREG + 1);

  xbs_ptr_type       pst [NREG];
  xbs_ptr_type       next_pst [NREG];
  logic [DATA_W-1:0] paddr [NREG];
  logic [DATA_W-1:0] next_paddr [NREG];
  logic [NREG-1:0]   share;
  logic [CNT_W-1:0]  share_cnt;
  wire logic         touch = pif.req || pif.upd;
  wire logic         ack_live;

  function automatic logic [CNT_W-1:0] ones(input logic [NREG-1:0] v);
    ones = '0;
    for (int i = 0; i < NREG; i++) begin
      ones = ones + CNT_W'(v[i]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-pointer state: line sharing match and next state.
  for (genvar r = 0; r < NREG; r++) begin : g_ptr
    wire logic sel = pif.preg == REG_W'(r);
    wire logic act = pst[r] inside {XBS_PT_CHECK, XBS_PT_VALID};
    wire logic ack = ack_live && tlb_ack_reg == REG_W'(r);
    assign share[r] = !sel && act &&
                      paddr[r][DATA_W-1:LINE_LSB] == pif.addr[DATA_W-1:LINE_LSB];
    // A fresh check or update wins over a late TLB answer for the same pointer.
    assign next_pst[r] = (sel && touch) ? (pif.conflict ? XBS_PT_NONE :
                                          (pif.req ? XBS_PT_CHECK : pst[r])) :
                         (pif.inv && pif.inv_reg == REG_W'(r)) ? XBS_PT_NONE :
                         ack ? (tlb_hit ? XBS_PT_VALID : XBS_PT_BAD) : pst[r];
    assign next_paddr[r] = (sel && touch) ? pif.addr : paddr[r];
  end

  // Sharing count and answers to the issue logic.
  assign share_cnt    = ones(share);
  assign pif.conflict = share_cnt >= CNT_W'(MAX_LINE_SHARE);
  assign pif.q_state  = pst[pif.preg];
  assign ack_live     = tlb_ack && pst[tlb_ack_reg] == XBS_PT_CHECK &&
                        !(touch && pif.preg == tlb_ack_reg);

  ////////////////////////////////////////////////////////////////////////////
  // State storage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pst   <= '{default: XBS_PT_NONE};
      paddr <= '{default: '0};
    end else begin
      pst   <= next_pst;
      paddr <= next_paddr;
    end
  end

  // TLB lookup requests; a lookup may start every cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tlb_req  <= 1'b0;
      tlb_reg  <= '0;
      tlb_addr <= '0;
    end else begin
      tlb_req  <= pif.req && !pif.conflict;
      tlb_reg  <= pif.preg;
      tlb_addr <= pif.addr;
    end
  end

  // Data prefetch on a hit, handler prefetch on a miss.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pf_valid   <= 1'b0;
      pf_addr    <= '0;
      pf_handler <= 1'b0;
    end else begin
      pf_valid   <= ack_live;
      pf_addr    <= tlb_hit ? paddr[tlb_ack_reg] : HANDLER_ADDR;
      pf_handler <= !tlb_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [REG_W-1:0] preg_q;
  always_ff @(posedge clk) begin
    preg_q <= pif.preg;
  end

  AST_MISS_HANDLER: assert property (@(posedge clk) disable iff (!rst_b)
    ack_live && !tlb_hit |=> pf_valid && pf_handler && pf_addr == HANDLER_ADDR)
    else $error("Missed pointer did not prefetch the handler.");
  AST_UPD_KEEPS: assert property (@(posedge clk) disable iff (!rst_b)
    pif.upd && !pif.conflict && pif.q_state == XBS_PT_VALID |=> pst[preg_q] == XBS_PT_VALID)
    else $error("Same page pointer update lost validity.");
  AST_LINE_SHARE: assert property (@(posedge clk) disable iff (!rst_b)
    touch && pif.conflict |=> pst[preg_q] == XBS_PT_NONE && !tlb_req)
    else $error("Third pointer on one cache line was accepted.");
endmodule // xbs_ptr_check
`default_nettype wire

/* File: dv/xbs_tlb_model.sv */
// Far-side TLB model that answers pointer checks after a settable delay.
`timescale 1ns/1ns
`default_nettype none
module xbs_tlb_model
  import xbs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              tlb_req,
  input  wire logic [REG_W-1:0]  tlb_reg,
  input  wire logic [DATA_W-1:0] tlb_addr,
  input  wire logic [7:0]        delay,
  output logic                   tlb_ack,
  output logic [REG_W-1:0]       tlb_ack_reg,
  output logic                   tlb_hit
);
  typedef struct packed {
    logic [REG_W-1:0] preg;
    logic             hit;
    int               due;
  } xbs_tlb_job_type;
  xbs_tlb_job_type job_q[$];
  int              cyc;
  ////////////////////////////////////////////////////////////////////////////////
  // Start quiet so the first edges see no answer.
  initial begin
    tlb_ack = 1'h0;
    tlb_ack_reg = 6'h00;
    tlb_hit = 1'h0;
    cyc = 0;
  end
  // Checks queue in order; an address with bit 40 set misses.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tlb_ack <= 1'h0;
    tlb_ack_reg <= ~tlb_ack_reg; // No stale tag between answers.
    tlb_hit <= ~tlb_hit;
    if (!rst_b) begin
      job_q.delete();
    end else begin
      if (tlb_req === 1'h1) begin
        job_q.push_back('{tlb_reg, ~tlb_addr[40], cyc + delay});
      end
      if (job_q.size() > 0 && job_q[0].due <= cyc) begin
        tlb_ack <= 1'h1;
        tlb_ack_reg <= job_q[0].preg;
        tlb_hit <= job_q[0].hit;
        void'(job_q.pop_front());
      end
    end
  end
endmodule // xbs_tlb_model
`default_nettype wire

/* File: dv/tb_xbs_pipe.sv */
// Self-checking bench of the crossbar scoreboard pipeline control.
`timescale 1ns/1ns
`default_nettype none
module tb_xbs_pipe;
  import xbs_pkg::*;
  localparam logic [DATA_W-1:0] HANDLER = 64'h0000_0000_0000_4000;
  typedef struct {
    xbs_op_type op; logic [1:0] s; xbs_cache_type ch; logic f; logic u; logic b;
  } xbs_row_type;
  logic clk, rst_b, iss_valid, iss_ready, iss_fault, xb_valid, ls_valid, ls_store;
  logic ls_unit, ls_bank, jmp_valid, tlb_req, tlb_ack, tlb_hit, pf_valid, pf_handler, flt;
  xbs_op_type iss_op, xb_op;
  xbs_cache_type iss_cache, ls_cache, hc;
  logic [REG_W-1:0] iss_src_a, iss_src_b, iss_dst, iss_ptr, xb_dst, ls_dst, tlb_reg;
  logic [REG_W-1:0] tlb_ack_reg;
  logic [DATA_W-1:0] iss_ptr_val, ls_addr, ls_ptr_next, jmp_target, tlb_addr, pf_addr, pv;
  logic [LAT_W-1:0] iss_lat;
  logic [IMM_W-1:0] iss_imm;
  logic [1:0] iss_stream, xb_sel_a, xb_sel_b, xb_wb_chan, hs;
  logic [7:0] delay;
  int st, err_total, checks;
  int lats[3] = '{1, 2, 4};
  xbs_row_type rows[5] = '{
    '{XBS_OP_LOAD, 2'h0, XBS_CH_KEEP, 1'h0, 1'h0, 1'h0},
    '{XBS_OP_STORE, 2'h1, XBS_CH_FLUSH, 1'h0, 1'h1, 1'h0},
    '{XBS_OP_LOAD, 2'h2, XBS_CH_BYPASS, 1'h0, 1'h0, 1'h1},
    '{XBS_OP_STORE, 2'h3, XBS_CH_KEEP, 1'h0, 1'h1, 1'h1},
    '{XBS_OP_LOAD, 2'h1, XBS_CH_RSVD, 1'h1, 1'h1, 1'h0}};
  xbs_pipe #(.HANDLER_ADDR(HANDLER)) xbs_pipe_inst (.*);
  xbs_tlb_model xbs_tlb_model_inst (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running bench clock.
  always #25 clk = ~clk;
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic c(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Offers one instruction and holds it until the edge that takes it.
  task automatic issue(input xbs_op_type op, input logic [5:0] a, d, p,
                       input logic [3:0] lat, input logic [63:0] v, input logic [15:0] imm);
    bit taken;
    taken = 0;
    st = 0;
    if (iss_valid !== 1'h1) @(posedge clk);
    iss_valid <= 1'h1;
    iss_op <= op;
    iss_src_a <= a;
    iss_dst <= d;
    iss_ptr <= p;
    iss_lat <= lat;
    iss_ptr_val <= v;
    iss_imm <= imm;
    iss_stream <= hs;
    iss_cache <= hc;
    while (!taken && st < 40) begin
      @(negedge clk);
      if (iss_ready === 1'h1) begin
        taken = 1;
        flt = iss_fault;
      end else begin
        st++;
      end
      @(posedge clk);
    end
    if (!taken) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic settle();
    iss_valid <= 1'h0;
    @(negedge clk);
  endtask
  task automatic wait_hi(input bit tlb);
    int n;
    n = 0;
    while ((tlb ? tlb_req : pf_valid) !== 1'h1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic assoc(input logic [5:0] p, input logic [63:0] a, input logic hit);
    issue(XBS_OP_ASSOC, 0, 0, p, 0, a, 0);
    settle();
    c("assoc fault", flt, 0);
    c("tlb_req", tlb_req, 1);
    c("tlb_reg", tlb_reg, p);
    c("tlb_addr", tlb_addr, a);
    wait_hi(0);
    c("pf_handler", pf_handler, !hit);
    c("pf_addr", pf_addr, hit ? a : HANDLER);
  endtask
  // Main sequence: reset, table of hinted accesses, then the awkward cases.
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    iss_valid = 1'h0;
    iss_op = XBS_OP_NONE;
    iss_src_a = 6'h00;
    iss_src_b = 6'h01;
    iss_dst = 6'h00;
    iss_ptr = 6'h00;
    iss_lat = 4'h0;
    iss_ptr_val = 64'h0;
    iss_imm = 16'h0;
    iss_stream = 2'h0;
    iss_cache = XBS_CH_KEEP;
    hs = 2'h0;
    hc = XBS_CH_KEEP;
    delay = 8'h02;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    c("rst xb_valid", xb_valid, 0);
    c("rst ls_valid", ls_valid, 0);
    c("rst tlb_req", tlb_req, 0);
    c("rst xb_op", xb_op, XBS_OP_NONE);
    assoc(2, 64'h2000, 1);
    pv = 64'h2000;
    foreach (rows[i]) begin
      hs = rows[i].s;
      hc = rows[i].ch;
      issue(rows[i].op, 0, 10, 2, 1, pv, 16'h0010);
      settle();
      c("fault", flt, rows[i].f);
      c("ls_valid", ls_valid, !rows[i].f);
      if (!rows[i].f) begin
        c("ls_store", ls_store, rows[i].op == XBS_OP_STORE);
        c("ls_dst", ls_dst, 10);
        c("ls_addr", ls_addr, pv);
        c("ls_ptr_next", ls_ptr_next, pv + 64'h10);
        c("ls_unit", ls_unit, rows[i].u);
        c("ls_bank", ls_bank, rows[i].b);
        c("ls_cache", ls_cache, rows[i].ch);
        pv = pv + 64'h10;
      end
    end
    hs = 2'h0;
    hc = XBS_CH_KEEP;
    issue(XBS_OP_LOAD, 0, 10, 2, 1, pv, 16'h0010);
    issue(XBS_OP_LOAD, 0, 11, 2, 1, pv + 64'h10, 16'h0010);
    c("b2b stall", st, 0);
    settle();
    c("b2b ls_addr", ls_addr, pv + 64'h10);
    pv = pv + 64'h20;
    delay = 8'h06;
    issue(XBS_OP_LOAD, 0, 10, 2, 1, pv, 16'h1000);
    settle();
    pv = pv + 64'h1000;
    wait_hi(1);
    c("recheck addr", tlb_addr, pv);
    issue(XBS_OP_LOAD, 0, 10, 2, 1, pv, 16'h0010);
    c("held for check", st > 0, 1);
    settle();
    c("ls_addr", ls_addr, pv);
    foreach (lats[k]) begin
      issue(XBS_OP_CALC, 20, 30 + k, 0, lats[k], 0, 0);
      issue(XBS_OP_CALC, 30 + k, 40 + k, 0, 1, 0, 0);
      c("dep stall", st, lats[k]);
      settle();
      c("bypass a", xb_sel_a != 0, 1);
      c("regset b", xb_sel_b, 0);
    end
    issue(XBS_OP_MOVE, 6, 7, 0, 0, 0, 0);
    issue(XBS_OP_MOVE, 7, 8, 0, 0, 0, 0);
    c("move stall", st, 0);
    settle();
    c("xb_valid", xb_valid, 1);
    c("xb_op", xb_op, XBS_OP_MOVE);
    c("xb_dst", xb_dst, 8);
    c("move bypass", xb_sel_a != 0, 1);
    // Two results landing in one cycle take both channels; a third must wait.
    issue(XBS_OP_CALC, 20, 50, 0, 2, 0, 0);
    issue(XBS_OP_CALC, 21, 51, 0, 1, 0, 0);
    settle();
    c("xb_wb_chan", xb_wb_chan, 1);
    issue(XBS_OP_CALC, 20, 52, 0, 2, 0, 0);
    issue(XBS_OP_CALC, 21, 53, 0, 1, 0, 0);
    issue(XBS_OP_CALC, 22, 54, 0, 0, 0, 0);
    c("wb full stall", st, 1);
    settle();
    c("wb chan free", xb_wb_chan, 0);
    // Second source pending: the consumer waits on operand b.
    issue(XBS_OP_CALC, 20, 1, 0, 2, 0, 0);
    issue(XBS_OP_CALC, 20, 55, 0, 1, 0, 0);
    c("src b stall", st, 2);
    settle();
    delay = 8'h01;
    assoc(4, 64'h0000_0100_0000_0000, 0);
    issue(XBS_OP_LOAD, 0, 10, 4, 1, 64'h0000_0100_0000_0000, 16'h0010);
    settle();
    c("bad fault", flt, 1);
    c("bad ls_valid", ls_valid, 0);
    assoc(11, 64'h5100, 1);
    assoc(12, 64'h5108, 1);
    issue(XBS_OP_ASSOC, 0, 0, 13, 0, 64'h5120, 0);
    settle();
    c("share fault", flt, 1);
    c("share tlb_req", tlb_req, 0);
    assoc(9, 64'h7000, 1);
    issue(XBS_OP_JUMP, 0, 0, 9, 0, 64'h7000, 0);
    settle();
    c("jmp_valid", jmp_valid, 1);
    c("jmp_target", jmp_target, 64'h7000);
    final_report();
  end
endmodule // tb_xbs_pipe
`default_nettype wire
